/* File: design/tecnt_regs.vh */
// register map, field positions, reset values and mode codes of the 16-bit timer/event counter
`ifndef TECNT_REGS_VH
`define TECNT_REGS_VH

// byte offsets in data memory
`define TECNT_ADDR_COUNT_HIGH 8'h20
`define TECNT_ADDR_COUNT_LOW 8'h21
`define TECNT_ADDR_CTRL 8'h22
`define TECNT_ADDR_RELOAD_HIGH 8'h23
`define TECNT_ADDR_RELOAD_LOW 8'h24
`define TECNT_ADDR_CONV_CTRL 8'h25

// counter_control fields
`define TECNT_CTRL_EDGE_BIT 3
`define TECNT_CTRL_RUN_BIT 4
`define TECNT_CTRL_MODE_LSB 5
`define TECNT_CTRL_MODE_MSB 7
// upper five bits after chip reset: mode 000, run 0, edge 1
`define TECNT_CTRL_MODE_RST 3'h0
`define TECNT_CTRL_RUN_RST 1'b0
`define TECNT_CTRL_EDGE_RST 1'b1

// converter_control fields
`define TECNT_CONV_OVSEL_BIT 0
`define TECNT_CONV_SEL_BIT 1
`define TECNT_CONV_OSC_LSB 2
`define TECNT_CONV_OSC_MSB 5
`define TECNT_CONV_OVSEL_RST 1'b0
`define TECNT_CONV_SEL_RST 1'b0
`define TECNT_CONV_OSC_RST 4'h8

// mode codes
`define TECNT_MODE_SYSCLK 3'h0
`define TECNT_MODE_SYSDIV4 3'h1
`define TECNT_MODE_RTC 3'h2
`define TECNT_MODE_CONVCLK 3'h3
`define TECNT_MODE_EVENT 3'h4
`define TECNT_MODE_PULSE 3'h5

// counting constants
`define TECNT_COUNT_MAX 16'hFFFF
`define TECNT_PRESCALE_LAST 2'h3

`endif

/* File: design/tecnt_top.v */
// 16-bit timer/event counter with buffered byte access and RC converter pairing
`timescale 1ns/1ps
`include "tecnt_regs.vh"
module tecnt_top #(
	parameter ADDR_W = 8
) (
	core_clk, // system clock
	rstn, // chip reset, active low
	addr, // register address
	wr_data, // write data
	wr_stb, // write strobe
	rd_stb, // read strobe
	rtc_tick, // rtc time-out pulse, core_clk domain
	count_input_pin, // external count input, asynchronous
	rc_osc_clk, // external rc oscillation, asynchronous
	rd_data, // read data, cycle after rd_stb
	counter_irq_flag, // one-cycle overflow request
	converter_mode, // converter_select bit
	osc_select // rc oscillation arrangement
);
	input wire core_clk;
	input wire rstn;
	input wire [ADDR_W-1:0] addr;
	input wire [7:0] wr_data;
	input wire wr_stb;
	input wire rd_stb;
	input wire rtc_tick;
	input wire count_input_pin;
	input wire rc_osc_clk;
	output wire [7:0] rd_data;
	output wire counter_irq_flag;
	output wire converter_mode;
	output wire [3:0] osc_select;

	// reset synchroniser
	reg rst_s1_ff;
	reg rst_s2_ff;
	wire rst_n;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	assign rst_n = rst_s2_ff;

	// input synchronisers and edge history: channel 0 count pin, channel 1 rc clock
	// only the second flop and the edge-history flop behind it feed logic; the first may be metastable
	wire [1:0] async_in = {rc_osc_clk, count_input_pin};
	wire [1:0] sync_lvl;
	wire [1:0] sync_prev;
	genvar g;

	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sync
			reg s1_ff;
			reg s2_ff;
			reg prev_ff;

			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					prev_ff <= 1'b0;
				end else begin
					s1_ff <= async_in[g];
					s2_ff <= s1_ff;
					prev_ff <= s2_ff;
				end
			end

			assign sync_lvl[g] = s2_ff;
			assign sync_prev[g] = prev_ff;
		end
	endgenerate

	wire pin_lvl = sync_lvl[0];
	wire pin_prev = sync_prev[0];
	wire rc_lvl = sync_lvl[1];
	wire rc_prev = sync_prev[1];

	// control state
	reg [2:0] mode_ff;
	reg run_ff;
	reg edge_ff;
	reg ovsel_ff;
	reg conv_ff;
	reg [3:0] osc_ff;
	reg pw_busy_ff;
	reg [1:0] pre4_ff;
	reg irq_ff;
	reg [7:0] rd_data_ff;

	// data state, kept across every reset
	reg [15:0] cnt_ff;
	reg [15:0] reload_ff;
	reg [7:0] reload_lo_buf_ff;
	reg [7:0] cnt_lo_wbuf_ff;
	reg [7:0] cnt_lo_rbuf_ff;

	reg [2:0] nxt_mode;
	reg nxt_run;
	reg nxt_edge;
	reg nxt_ovsel;
	reg nxt_conv;
	reg [3:0] nxt_osc;
	reg nxt_pw_busy;
	reg nxt_irq;
	reg [7:0] nxt_rd_data;
	reg [15:0] nxt_cnt;
	reg [15:0] nxt_reload;
	reg [7:0] nxt_reload_lo_buf;
	reg [7:0] nxt_cnt_lo_wbuf;
	reg [7:0] nxt_cnt_lo_rbuf;

	// register decode
	wire sel_cnt_hi = (addr == `TECNT_ADDR_COUNT_HIGH);
	wire sel_cnt_lo = (addr == `TECNT_ADDR_COUNT_LOW);
	wire sel_ctrl = (addr == `TECNT_ADDR_CTRL);
	wire sel_rel_hi = (addr == `TECNT_ADDR_RELOAD_HIGH);
	wire sel_rel_lo = (addr == `TECNT_ADDR_RELOAD_LOW);
	wire sel_conv = (addr == `TECNT_ADDR_CONV_CTRL);

	// event qualification
	wire instr_tick = (pre4_ff == `TECNT_PRESCALE_LAST);
	wire pin_rise = pin_lvl & ~pin_prev;
	wire pin_fall = ~pin_lvl & pin_prev;
	wire pin_edge = edge_ff ? pin_fall : pin_rise;
	wire pin_active_lvl = edge_ff ? ~pin_lvl : pin_lvl;
	wire rc_rise = rc_lvl & ~rc_prev;

	reg internal_tick;
	reg a_tick;

	always @* begin
		case (mode_ff)
			`TECNT_MODE_SYSCLK: internal_tick = 1'b1;
			`TECNT_MODE_SYSDIV4: internal_tick = instr_tick;
			`TECNT_MODE_RTC: internal_tick = rtc_tick;
			default: internal_tick = 1'b0;
		endcase
	end

	always @* begin
		case (mode_ff)
			`TECNT_MODE_SYSCLK,
			`TECNT_MODE_SYSDIV4,
			`TECNT_MODE_RTC: a_tick = internal_tick;
			`TECNT_MODE_CONVCLK: a_tick = conv_ff ? 1'b0 : rc_rise;
			`TECNT_MODE_EVENT: a_tick = conv_ff ? 1'b0 : pin_edge;
			`TECNT_MODE_PULSE: a_tick = conv_ff ? 1'b0 :
				(pw_busy_ff & pin_active_lvl & instr_tick);
			default: a_tick = 1'b0;
		endcase
	end

	// timer b counts the rc clock only when paired as converter
	wire b_tick = conv_ff & rc_rise;
	wire a_ovf = run_ff & a_tick & (cnt_ff == `TECNT_COUNT_MAX);
	wire b_ovf = run_ff & b_tick & (reload_ff == `TECNT_COUNT_MAX);
	wire conv_ovf = ovsel_ff ? b_ovf : a_ovf;

	always @* begin
		nxt_mode = mode_ff;
		nxt_run = run_ff;
		nxt_edge = edge_ff;
		nxt_ovsel = ovsel_ff;
		nxt_conv = conv_ff;
		nxt_osc = osc_ff;
		nxt_pw_busy = pw_busy_ff;
		nxt_irq = 1'b0;
		nxt_cnt = cnt_ff;
		nxt_reload = reload_ff;
		nxt_reload_lo_buf = reload_lo_buf_ff;
		nxt_cnt_lo_wbuf = cnt_lo_wbuf_ff;

		// timer a
		if (run_ff && a_tick) begin
			if (cnt_ff == `TECNT_COUNT_MAX && !conv_ff) begin
				nxt_cnt = reload_ff;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end

		// timer b in converter pairing
		if (run_ff && b_tick) begin
			nxt_reload = reload_ff + 16'h0001;
		end

		if (conv_ff) begin
			if (conv_ovf) begin
				nxt_irq = 1'b1;
				nxt_run = 1'b0;
			end
		end else begin
			nxt_irq = a_ovf;
		end

		// pulse width: arm on active edge, stop when the level returns
		if (mode_ff == `TECNT_MODE_PULSE && !conv_ff && run_ff) begin
			if (!pw_busy_ff && pin_edge) begin
				nxt_pw_busy = 1'b1;
			end else if (pw_busy_ff && !pin_active_lvl) begin
				nxt_pw_busy = 1'b0;
				nxt_run = 1'b0;
			end
		end else begin
			nxt_pw_busy = 1'b0;
		end

		// software writes take priority over counting
		if (wr_stb) begin
			if (sel_cnt_lo) begin
				nxt_cnt_lo_wbuf = wr_data;
			end
			if (sel_cnt_hi) begin
				nxt_cnt = {wr_data, cnt_lo_wbuf_ff};
			end
			if (sel_rel_lo) begin
				nxt_reload_lo_buf = wr_data;
			end
			if (sel_rel_hi) begin
				nxt_reload = {wr_data, reload_lo_buf_ff};
				if (!run_ff && !conv_ff) begin
					nxt_cnt = {wr_data, reload_lo_buf_ff};
				end
			end
			if (sel_ctrl) begin
				nxt_mode = wr_data[`TECNT_CTRL_MODE_MSB:`TECNT_CTRL_MODE_LSB];
				nxt_run = wr_data[`TECNT_CTRL_RUN_BIT];
				nxt_edge = wr_data[`TECNT_CTRL_EDGE_BIT];
				nxt_pw_busy = 1'b0;
			end
			if (sel_conv) begin
				nxt_ovsel = wr_data[`TECNT_CONV_OVSEL_BIT];
				nxt_conv = wr_data[`TECNT_CONV_SEL_BIT];
				nxt_osc = wr_data[`TECNT_CONV_OSC_MSB:`TECNT_CONV_OSC_LSB];
			end
		end

	end

	// read mux; a count high read snapshots the low byte so a 16-bit read is not torn
	always @* begin
		nxt_rd_data = 8'h00;
		nxt_cnt_lo_rbuf = cnt_lo_rbuf_ff;
		if (rd_stb) begin
			case (1'b1)
				sel_cnt_hi: begin
					nxt_rd_data = cnt_ff[15:8];
					nxt_cnt_lo_rbuf = cnt_ff[7:0];
				end
				sel_cnt_lo: begin
					nxt_rd_data = cnt_lo_rbuf_ff;
				end
				sel_ctrl: begin
					nxt_rd_data = {mode_ff, run_ff, edge_ff, 3'h0};
				end
				sel_rel_hi: begin
					nxt_rd_data = reload_ff[15:8];
				end
				sel_rel_lo: begin
					nxt_rd_data = reload_ff[7:0];
				end
				sel_conv: begin
					nxt_rd_data = {2'h0, osc_ff, conv_ff, ovsel_ff};
				end
				default: begin
					// unmapped addresses read zero
					nxt_rd_data = 8'h00;
				end
			endcase
		end
	end

	// control registers: restored on every chip reset
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= `TECNT_CTRL_MODE_RST;
			run_ff <= `TECNT_CTRL_RUN_RST;
			edge_ff <= `TECNT_CTRL_EDGE_RST;
			ovsel_ff <= `TECNT_CONV_OVSEL_RST;
			conv_ff <= `TECNT_CONV_SEL_RST;
			osc_ff <= `TECNT_CONV_OSC_RST;
			pw_busy_ff <= 1'b0;
			pre4_ff <= 2'h0;
			irq_ff <= 1'b0;
			rd_data_ff <= 8'h00;
		end else begin
			mode_ff <= nxt_mode;
			run_ff <= nxt_run;
			edge_ff <= nxt_edge;
			ovsel_ff <= nxt_ovsel;
			conv_ff <= nxt_conv;
			osc_ff <= nxt_osc;
			pw_busy_ff <= nxt_pw_busy;
			pre4_ff <= pre4_ff + 2'h1;
			irq_ff <= nxt_irq;
			rd_data_ff <= nxt_rd_data;
		end
	end

	// data registers: no reset, so a chip reset leaves them intact
	always @(posedge core_clk) begin
		cnt_ff <= nxt_cnt;
		reload_ff <= nxt_reload;
		reload_lo_buf_ff <= nxt_reload_lo_buf;
		cnt_lo_wbuf_ff <= nxt_cnt_lo_wbuf;
		cnt_lo_rbuf_ff <= nxt_cnt_lo_rbuf;
	end

	assign rd_data = rd_data_ff;
	assign counter_irq_flag = irq_ff;
	assign converter_mode = conv_ff;
	assign osc_select = osc_ff;

endmodule // tecnt_top

/* File: verif/tecnt_asserts.sv */
// checker on the timer/event counter top-level ports
`timescale 1ns/1ps
module tecnt_asserts #(parameter ADDR_W = 8) (
	input wire core_clk, // clock
	input wire rstn, // reset
	input wire [ADDR_W-1:0] addr, // address
	input wire [7:0] wr_data, // write data
	input wire wr_stb, // write strobe
	input wire rd_stb, // read strobe
	input wire [7:0] rd_data, // read data
	input wire counter_irq_flag, // overflow pulse
	input wire converter_mode, // converter select
	input wire [3:0] osc_select // rc arrangement
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_rd(a);
		rd_stb && addr == a;
	endsequence
	sequence s_wr(a);
		wr_stb && addr == a;
	endsequence
	chk_rd_idle:
	assert property (!rd_stb |=> rd_data == 8'h00) else $error("rd_data not idle");
	chk_unmapped_rd:
	assert property (rd_stb && (addr < 8'h20 || addr > 8'h25) |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	chk_ctrl_unused:
	assert property (s_rd(8'h22) |=> rd_data[2:0] == 3'h0) else $error("ctrl low bits");
	chk_conv_readback:
	assert property (s_rd(8'h25) |=> rd_data == {2'h0, $past(osc_select), $past(converter_mode), 1'b0}
		|| rd_data[7:1] == {2'h0, $past(osc_select), $past(converter_mode)})
		else $error("converter readback");
	chk_conv_write:
	assert property (s_wr(8'h25) |=> converter_mode == $past(wr_data[1])
		&& osc_select == $past(wr_data[5:2])) else $error("converter write");
	chk_conv_hold:
	assert property (!(wr_stb && addr == 8'h25) |=> $stable(converter_mode) && $stable(osc_select))
		else $error("converter changed");
	chk_reset_vals:
	assert property ($rose(rstn) |-> !converter_mode && osc_select == 4'h8)
		else $error("reset values");
	chk_irq_quiet:
	assert property ($rose(rstn) |-> !counter_irq_flag [*3]) else $error("irq after reset");
endmodule // tecnt_asserts
bind tecnt_top tecnt_asserts #(.ADDR_W(ADDR_W)) tecnt_asserts_inst (.core_clk(core_clk),
	.rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rd_data(rd_data), .counter_irq_flag(counter_irq_flag), .converter_mode(converter_mode),
	.osc_select(osc_select));

/* File: verif/tecnt_far.sv */
// far-side model: count input pin, rc oscillator, rtc tick
`timescale 1ns/1ps
module tecnt_far (
	input wire core_clk, // clock
	output reg count_input_pin, // event pin
	output reg rc_osc_clk, // still outside bursts
	output reg rtc_tick // one-cycle tick
);
	initial begin
		count_input_pin = 1'b0;
		rc_osc_clk = 1'b0;
		rtc_tick = 1'b0;
	end
	task set_pin(input v);
		#637 count_input_pin = v;
	endtask
	task pin_pulses(input integer n);
		repeat (n) begin
			set_pin(1'b1);
			set_pin(1'b0);
		end
	endtask
	task rc_pulses(input integer n);
		repeat (n) begin
			#413 rc_osc_clk = 1'b1;
			#413 rc_osc_clk = 1'b0;
		end
	endtask
	task rtc(input integer n);
		repeat (n) begin
			@(posedge core_clk);
			rtc_tick <= 1'b1;
			@(posedge core_clk);
			rtc_tick <= 1'b0;
			@(posedge core_clk);
		end
	endtask
endmodule // tecnt_far

/* File: verif/tecnt_top_tb.sv */
// self-checking bench for the 16-bit timer/event counter
`timescale 1ns/1ps
module tecnt_top_tb;
	reg core_clk = 1'b0;
	reg rstn = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [7:0] wr_data = 8'h00;
	reg wr_stb = 1'b0;
	reg rd_stb = 1'b0;
	wire rtc_tick, count_input_pin, rc_osc_clk, counter_irq_flag, converter_mode;
	wire [7:0] rd_data;
	wire [3:0] osc_select;
	integer failures = 0;
	integer cmp_count = 0;
	integer cycles = 0;
	integer i;
	reg [15:0] v;
	reg [7:0] b;
	always #50 core_clk = ~core_clk;
	tecnt_top tecnt_top_inst (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rtc_tick(rtc_tick), .count_input_pin(count_input_pin),
		.rc_osc_clk(rc_osc_clk), .rd_data(rd_data), .counter_irq_flag(counter_irq_flag),
		.converter_mode(converter_mode), .osc_select(osc_select));
	tecnt_far tecnt_far_inst (.core_clk(core_clk), .count_input_pin(count_input_pin),
		.rc_osc_clk(rc_osc_clk), .rtc_tick(rtc_tick));
	task test_done;
		$display("failures=%0d comparisons=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string n, input [15:0] s, input [15:0] e);
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask
	task rd(input [7:0] a, output [7:0] d);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask
	task rdc(output [15:0] c);
		rd(8'h20, c[15:8]);
		rd(8'h21, c[7:0]);
	endtask
	task ldc(input [15:0] c);
		wr(8'h21, c[7:0]);
		wr(8'h20, c[15:8]);
	endtask
	task run(input [7:0] c);
		ldc(16'h0000);
		wr(8'h22, c);
	endtask
	task stopc(input [15:0] e);
		wr(8'h22, 8'h08);
		rdc(v);
		chk("count", v, e);
	endtask
	task t_reset;
		rd(8'h22, b);
		chk("ctrl", b, 8'h08);
		rd(8'h25, b);
		chk("conv", b, 8'h20);
		rd(8'h26, b);
		chk("unmapped", b, 8'h00);
	endtask
	task t_reload;
		wr(8'h24, 8'h34);
		wr(8'h23, 8'h12);
		rdc(v);
		chk("reload", v, 16'h1234);
		wr(8'h24, 8'hAA);
		rdc(v);
		chk("buffer", v, 16'h1234);
		ldc(16'h5678);
		rd(8'h21, b);
		chk("old capture", b, 8'h34);
	endtask
	task t_overflow;
		ldc(16'hFFFE);
		wr(8'h22, 8'h18);
		i = 0;
		while (counter_irq_flag !== 1'b1 && i < 8) begin
			@(posedge core_clk);
			#1 i = i + 1;
		end
		chk("irq delay", i, 2);
		wr(8'h22, 8'h08);
		rd(8'h20, b);
		chk("reloaded", b, 8'h12);
	endtask
	task t_div4;
		run(8'h38);
		#4000 wr(8'h22, 8'h08);
		rdc(v);
		chk("div4", v >= 16'd9 && v <= 16'd12, 1'b1);
	endtask
	task t_event;
		for (i = 0; i < 2; i = i + 1) begin
			run(8'h90 | (i << 3));
			tecnt_far_inst.pin_pulses(3);
			tecnt_far_inst.set_pin(1'b1);
			#1000 stopc(4 - i);
			tecnt_far_inst.set_pin(1'b0);
		end
	endtask
	task t_sources;
		run(8'h50);
		tecnt_far_inst.rtc(3);
		stopc(16'd3);
		run(8'h70);
		tecnt_far_inst.rc_pulses(4);
		#1000 stopc(16'd4);
		for (i = 6; i < 8; i = i + 1) begin
			run((i << 5) | 8'h10);
			#2000 stopc(16'd0);
		end
	endtask
	task t_pulse;
		tecnt_far_inst.set_pin(1'b1);
		run(8'hB8);
		#1000 tecnt_far_inst.set_pin(1'b0);
		#4000 tecnt_far_inst.set_pin(1'b1);
		#1500 rdc(v);
		chk("width", v >= 16'd9 && v <= 16'd11, 1'b1);
		rd(8'h22, b);
		chk("auto stop", b, 8'hA8);
	endtask
	task t_conv;
		wr(8'h25, 8'h3E);
		#1 chk("conv mode", {converter_mode, osc_select}, 5'h1F);
		wr(8'h25, 8'h20);
		#1 chk("counter mode", {converter_mode, osc_select}, 5'h08);
	endtask
	task t_rst2;
		ldc(16'h5555);
		wr(8'h22, 8'hE7);
		rstn <= 1'b0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset;
		rdc(v);
		chk("kept", v, 16'h5555);
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset;
		t_reload;
		t_overflow;
		t_div4;
		t_event;
		t_sources;
		t_pulse;
		t_conv;
		t_rst2;
		test_done;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			test_done;
		end
	end
endmodule // tecnt_top_tb
